// ---- card_intf_cfg.svh ----
// Constants of the card interface control: timing counts and reset values.
// Assumes a 50 MHz reference clock; included by bare name wherever needed.
`ifndef CARD_INTF_CFG_SVH
`define CARD_INTF_CFG_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_PERIOD_NS      20

// ----------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------
`define UNDERVOLT_TIME_NS  5000
`define UNDERVOLT_CYCLES   (`UNDERVOLT_TIME_NS / `CLK_PERIOD_NS)
`define MISMATCH_TIME_NS   3000
`define MISMATCH_CYCLES    (`MISMATCH_TIME_NS / `CLK_PERIOD_NS)
`define DEBOUNCE_MIN_MS    40
`define DEBOUNCE_TYP_MS    80
`define DEBOUNCE_CYCLES    (`DEBOUNCE_TYP_MS * 1000000 / `CLK_PERIOD_NS)

// ----------------------------------------
// Reset values and channel count
// ----------------------------------------
`define FLAG_N_RST         1'b1
`define LEVEL_RST          1'b0
`define CHAN_COUNT         3

`endif

// ---- card_intf_ctrl.sv ----
// Control core of a level-translating smart card interface.
// Assumes synchronous inputs, analog supply status on a comparator input,
// and pads resolved outside from the out/enable pairs.
//
// Contract
// - Activation request low starts the ramp state and the card supply.
// - Supply good goes low only once the card supply is regulated.
// - Card reset and clock stay disabled until supply good is low.
// - Data channels enable after supply good, and only while selected.
// - Supply level is latched on activation falling edge, then ignored.
// - Channel select low enables data channels; high disables them.
// - Disabled channels release the host side; card side is forced high, or low in idle and alarm.
// - Select may fall with activation; traffic still waits for supply good.
// - Channel select never touches supply, card clock or card reset.
// - Switch polarity select high means active-high switch, low active-low.
// - An inserted card always shows as insertion flag low.
// - Switch changes are debounced for about 80 ms before reporting.
// - Reduced variant ties select to activation and fixes normally open.
// - Channels idle high, lock direction on first low, release at idle.
// - Supply below level for 5 us forces alarm and discharge.
// - Card reset or clock differing from host input for 3 us alarms.
// - In idle the card reset and clock are held low.
`include "card_intf_cfg.svh"

module card_intf_ctrl #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter bit REDUCED_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_I,
  // Host controls
  input  wire logic       ACTIVATION_REQUEST_N_I,
  input  wire logic       CHANNEL_SELECT_N_I,
  input  wire logic       SUPPLY_LEVEL_SELECT_I,
  input  wire logic       SWITCH_POLARITY_SELECT_I,
  input  wire logic       HOST_RESET_IN_I,
  input  wire logic       HOST_CLOCK_IN_I,
  // Card acceptor and analog sense
  input  wire logic       ACCEPTOR_SWITCH_IN_I,
  input  wire logic       SUPPLY_IN_RANGE_I,
  input  wire logic       CARD_RESET_SENSE_I,
  input  wire logic       CARD_CLOCK_SENSE_I,
  // Data lines: bit 0 data, bit 1 spare a, bit 2 spare b
  input  wire logic [2:0] HOST_LINE_IN_I,
  output logic      [2:0] HOST_LINE_OUT_O,
  output logic      [2:0] HOST_LINE_OE_O,
  input  wire logic [2:0] CARD_LINE_IN_I,
  output logic      [2:0] CARD_LINE_OUT_O,
  output logic      [2:0] CARD_LINE_OE_O,
  // Supply generator
  output logic            SUPPLY_ENABLE_O,
  output logic            SUPPLY_DISCHARGE_O,
  output logic            SUPPLY_LEVEL_O,
  // Status
  output logic            SUPPLY_GOOD_N_O,
  output logic            ALARM_N_O,
  output logic            INSERTION_FLAG_N_O,
  // Card reset and clock
  output logic            CARD_RESET_OUT_O,
  output logic            CARD_CLOCK_OUT_O
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam int UV_CYCLES = `UNDERVOLT_CYCLES;
  localparam int MM_CYCLES = `MISMATCH_CYCLES;
  localparam int UV_W      = $clog2(UV_CYCLES + 1);
  localparam int MM_W      = $clog2(MM_CYCLES + 1);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  card_intf_pkg::power_state_t state_reg, state_next;

  logic            act_prev_reg;
  logic            act_fall;
  logic            chan_sel_n;
  logic            switch_pol;
  logic [UV_W-1:0] uv_cnt_reg;
  logic [MM_W-1:0] mm_cnt_reg;
  logic            uv_trip;
  logic            mm_trip;
  logic            mismatch;
  logic            chan_en_reg;
  logic            chan_park_reg;

  chan_if ch [`CHAN_COUNT] ();

  // ----------------------------------------
  // Variant straps
  // ----------------------------------------

  // Reduced part has no select or polarity pin of its own
  assign chan_sel_n = REDUCED_VARIANT ? ACTIVATION_REQUEST_N_I
                                      : CHANNEL_SELECT_N_I;
  assign switch_pol = REDUCED_VARIANT ? 1'b0
                                      : SWITCH_POLARITY_SELECT_I;

  // ----------------------------------------
  // Activation edge
  // ----------------------------------------

  // Previous level resets high, so a request held low through reset
  // still counts as a falling edge once reset is released
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      act_prev_reg <= 1'b1;
    else
      act_prev_reg <= ACTIVATION_REQUEST_N_I;
  end

  assign act_fall = act_prev_reg & ~ACTIVATION_REQUEST_N_I;

  // ----------------------------------------
  // Supply level latch
  // ----------------------------------------

  // Taken only on the falling edge; later changes are ignored
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      SUPPLY_LEVEL_O <= `LEVEL_RST;
    else if (act_fall)
      SUPPLY_LEVEL_O <= SUPPLY_LEVEL_SELECT_I;
  end

  // ----------------------------------------
  // Fault timers
  // ----------------------------------------

  // Undervoltage timer runs only once the supply was declared good
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      uv_cnt_reg <= '0;
    else if (state_reg != card_intf_pkg::SUP_ACTIVE || SUPPLY_IN_RANGE_I)
      uv_cnt_reg <= '0;
    else if (!uv_trip)
      uv_cnt_reg <= uv_cnt_reg + 1'b1;
  end

  assign uv_trip = (uv_cnt_reg == UV_W'(UV_CYCLES));

  // Pad readback against host input; the timer length also hides
  // the one-cycle lag of the registered card outputs
  assign mismatch = (CARD_RESET_SENSE_I != CARD_RESET_OUT_O)
                  | (CARD_CLOCK_SENSE_I != CARD_CLOCK_OUT_O)
                  | (CARD_RESET_OUT_O != HOST_RESET_IN_I)
                  | (CARD_CLOCK_OUT_O != HOST_CLOCK_IN_I);

  // Consecutive mismatch cycles, checked only in the active state
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      mm_cnt_reg <= '0;
    else if (state_reg != card_intf_pkg::SUP_ACTIVE || !mismatch)
      mm_cnt_reg <= '0;
    else if (!mm_trip)
      mm_cnt_reg <= mm_cnt_reg + 1'b1;
  end

  assign mm_trip = (mm_cnt_reg == MM_W'(MM_CYCLES));

  // ----------------------------------------
  // Power sequence
  // ----------------------------------------

  // Releasing the request always returns to idle, also from alarm
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      card_intf_pkg::SUP_IDLE:
      begin
        if (act_fall)
          state_next = card_intf_pkg::SUP_RAMP;
      end
      card_intf_pkg::SUP_RAMP:
      begin
        if (ACTIVATION_REQUEST_N_I)
          state_next = card_intf_pkg::SUP_IDLE;
        else if (SUPPLY_IN_RANGE_I)
          state_next = card_intf_pkg::SUP_ACTIVE;
      end
      card_intf_pkg::SUP_ACTIVE:
      begin
        if (ACTIVATION_REQUEST_N_I)
          state_next = card_intf_pkg::SUP_IDLE;
        else if (uv_trip || mm_trip)
          state_next = card_intf_pkg::SUP_ALARM;
      end
      card_intf_pkg::SUP_ALARM:
      begin
        if (ACTIVATION_REQUEST_N_I)
          state_next = card_intf_pkg::SUP_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      state_reg <= card_intf_pkg::SUP_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // Supply and status outputs
  // ----------------------------------------

  // Decoded from the next state so they switch with the state flop
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      SUPPLY_ENABLE_O    <= 1'b0;
      SUPPLY_DISCHARGE_O <= 1'b1;
      SUPPLY_GOOD_N_O    <= 1'b1;
      ALARM_N_O          <= 1'b1;
    end
    else
    begin
      SUPPLY_ENABLE_O    <= (state_next == card_intf_pkg::SUP_RAMP)
                          | (state_next == card_intf_pkg::SUP_ACTIVE);
      SUPPLY_DISCHARGE_O <= (state_next == card_intf_pkg::SUP_IDLE)
                          | (state_next == card_intf_pkg::SUP_ALARM);
      SUPPLY_GOOD_N_O    <= (state_next != card_intf_pkg::SUP_ACTIVE);
      ALARM_N_O          <= (state_next != card_intf_pkg::SUP_ALARM);
    end
  end

  // ----------------------------------------
  // Card reset and clock
  // ----------------------------------------

  // Follow the host only while active; held low otherwise
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      CARD_RESET_OUT_O <= 1'b0;
      CARD_CLOCK_OUT_O <= 1'b0;
    end
    else if (state_next == card_intf_pkg::SUP_ACTIVE)
    begin
      CARD_RESET_OUT_O <= HOST_RESET_IN_I;
      CARD_CLOCK_OUT_O <= HOST_CLOCK_IN_I;
    end
    else
    begin
      CARD_RESET_OUT_O <= 1'b0;
      CARD_CLOCK_OUT_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // Data channel gating
  // ----------------------------------------

  // Select may fall early; the supply state still holds traffic back
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      chan_en_reg   <= 1'b0;
      chan_park_reg <= 1'b1;
    end
    else
    begin
      chan_en_reg   <= (state_next == card_intf_pkg::SUP_ACTIVE)
                     & ~chan_sel_n;
      chan_park_reg <= (state_next == card_intf_pkg::SUP_IDLE)
                     | (state_next == card_intf_pkg::SUP_ALARM);
    end
  end

  // ----------------------------------------
  // Data channels
  // ----------------------------------------

  // Same channel logic for data and both spare lines
  for (genvar g = 0; g < `CHAN_COUNT; g++)
  begin : g_chan
    assign ch[g].en      = chan_en_reg;
    assign ch[g].park    = chan_park_reg;
    assign ch[g].host_in = HOST_LINE_IN_I[g];
    assign ch[g].card_in = CARD_LINE_IN_I[g];

    io_channel u_chan (
      .clk_i (REF_CLK_I),
      .rst_i (RST_I),
      .ch    (ch[g])
    );

    // Pad drivers are flops inside the channel
    assign HOST_LINE_OUT_O[g] = ch[g].host_out;
    assign HOST_LINE_OE_O[g]  = ch[g].host_oe;
    assign CARD_LINE_OUT_O[g] = ch[g].card_out;
    assign CARD_LINE_OE_O[g]  = ch[g].card_oe;
  end

  // ----------------------------------------
  // Card presence
  // ----------------------------------------

  // Long debounce runs regardless of the power state
  insert_debounce #(
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_i    (REF_CLK_I),
    .rst_i    (RST_I),
    .sw_i     (ACCEPTOR_SWITCH_IN_I),
    .pol_i    (switch_pol),
    .flag_n_o (INSERTION_FLAG_N_O)
  );

endmodule : card_intf_ctrl

// ---- card_intf_monitor.sv ----
// Concurrent checks on the card interface control top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
module card_intf_monitor #(
  parameter int DEBOUNCE_CYCLES = 16
) (
  // Clock and reset
  input wire logic       REF_CLK_I,
  input wire logic       RST_I,
  // Inputs watched
  input wire logic       ACTIVATION_REQUEST_N_I,
  input wire logic       CHANNEL_SELECT_N_I,
  input wire logic       SUPPLY_LEVEL_SELECT_I,
  input wire logic       SWITCH_POLARITY_SELECT_I,
  input wire logic       ACCEPTOR_SWITCH_IN_I,
  input wire logic       SUPPLY_IN_RANGE_I,
  // Outputs watched
  input wire logic [2:0] HOST_LINE_OE_O,
  input wire logic [2:0] CARD_LINE_OUT_O,
  input wire logic [2:0] CARD_LINE_OE_O,
  input wire logic       SUPPLY_ENABLE_O,
  input wire logic       SUPPLY_LEVEL_O,
  input wire logic       SUPPLY_GOOD_N_O,
  input wire logic       INSERTION_FLAG_N_O,
  input wire logic       CARD_RESET_OUT_O,
  input wire logic       CARD_CLOCK_OUT_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic present;
  logic prs_reg;
  int   stab_reg;
  int   uv_reg;
  assign present = SWITCH_POLARITY_SELECT_I ? ACCEPTOR_SWITCH_IN_I : !ACCEPTOR_SWITCH_IN_I;

  // Cycles since the corrected switch last moved; saturates to avoid wrap
  always_ff @(posedge REF_CLK_I)
  begin
    prs_reg  <= present;
    stab_reg <= (RST_I || present != prs_reg) ? 0 : (stab_reg < 1000000 ? stab_reg + 1 : stab_reg);
  end

  // Consecutive low-supply cycles while active
  always_ff @(posedge REF_CLK_I)
    uv_reg <= (!RST_I && !SUPPLY_IN_RANGE_I && !SUPPLY_GOOD_N_O) ? uv_reg + 1 : 0;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_off;
    (CHANNEL_SELECT_N_I || SUPPLY_GOOD_N_O) [*4];
  endsequence
  property p_activate;
    $fell(ACTIVATION_REQUEST_N_I) |=> SUPPLY_ENABLE_O && SUPPLY_LEVEL_O == $past(SUPPLY_LEVEL_SELECT_I);
  endproperty
  property p_level_hold;
    (!ACTIVATION_REQUEST_N_I && !RST_I) [*3] |-> $stable(SUPPLY_LEVEL_O);
  endproperty
  property p_good_cause;
    $fell(SUPPLY_GOOD_N_O) |-> $past(SUPPLY_IN_RANGE_I);
  endproperty
  property p_card_off;
    SUPPLY_GOOD_N_O [*2] |-> !CARD_RESET_OUT_O && !CARD_CLOCK_OUT_O;
  endproperty
  property p_host_release;
    s_off |-> HOST_LINE_OE_O == 3'h0;
  endproperty
  property p_uv_bound;
    uv_reg < 254;
  endproperty
  property p_flag_wait;
    $changed(INSERTION_FLAG_N_O) |-> stab_reg >= DEBOUNCE_CYCLES - 1 && INSERTION_FLAG_N_O == !$past(present);
  endproperty
  property p_idle_low;
    ACTIVATION_REQUEST_N_I [*3] |-> !CARD_RESET_OUT_O && !CARD_CLOCK_OUT_O && CARD_LINE_OUT_O == 3'h0
      && CARD_LINE_OE_O == 3'h7;
  endproperty

  a_activate:     assert property (p_activate) else $error("supply not started after request");
  a_level_hold:   assert property (p_level_hold) else $error("level changed while active");
  a_good_cause:   assert property (p_good_cause) else $error("good without supply in range");
  a_card_off:     assert property (p_card_off) else $error("card reset or clock live early");
  a_host_release: assert property (p_host_release) else $error("host line pulled while disabled");
  a_uv_bound:     assert property (p_uv_bound) else $error("no alarm on long undervoltage");
  a_flag_wait:    assert property (p_flag_wait) else $error("flag moved before debounce");
  a_idle_low:     assert property (p_idle_low) else $error("card lines not low in idle");
endmodule : card_intf_monitor

bind card_intf_ctrl card_intf_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_mon (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ACTIVATION_REQUEST_N_I(ACTIVATION_REQUEST_N_I),
  .CHANNEL_SELECT_N_I(CHANNEL_SELECT_N_I), .SUPPLY_LEVEL_SELECT_I(SUPPLY_LEVEL_SELECT_I),
  .SWITCH_POLARITY_SELECT_I(SWITCH_POLARITY_SELECT_I), .ACCEPTOR_SWITCH_IN_I(ACCEPTOR_SWITCH_IN_I),
  .SUPPLY_IN_RANGE_I(SUPPLY_IN_RANGE_I), .HOST_LINE_OE_O(HOST_LINE_OE_O), .CARD_LINE_OUT_O(CARD_LINE_OUT_O),
  .CARD_LINE_OE_O(CARD_LINE_OE_O), .SUPPLY_ENABLE_O(SUPPLY_ENABLE_O), .SUPPLY_LEVEL_O(SUPPLY_LEVEL_O),
  .SUPPLY_GOOD_N_O(SUPPLY_GOOD_N_O), .INSERTION_FLAG_N_O(INSERTION_FLAG_N_O),
  .CARD_RESET_OUT_O(CARD_RESET_OUT_O), .CARD_CLOCK_OUT_O(CARD_CLOCK_OUT_O));

// ---- card_intf_pkg.sv ----
// Types shared by the card interface control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package card_intf_pkg;

  // ----------------------------------------
  // Power sequence and channel direction
  // ----------------------------------------
  typedef enum logic [1:0] {SUP_IDLE, SUP_RAMP, SUP_ACTIVE, SUP_ALARM} power_state_t;
  typedef enum logic [1:0] {DIR_IDLE, DIR_H2C, DIR_C2H} chan_dir_t;

endpackage : card_intf_pkg

// ---- chan_if.sv ----
// Carrier between the control core and one half-duplex data channel.
// Assumes the control side drives enable and park, the channel the pads.
interface chan_if;
  logic en;        // Channel may pass data
  logic park;      // Card side held low (idle or alarm)
  logic host_in;
  logic card_in;
  logic host_out;
  logic host_oe;
  logic card_out;
  logic card_oe;

  modport ctl (output en, park, host_in, card_in,
               input  host_out, host_oe, card_out, card_oe);
  modport chan (input  en, park, host_in, card_in,
                output host_out, host_oe, card_out, card_oe);
endinterface : chan_if

// ---- far_side_model.sv ----
// Host and card contacts: pull-ups, open-drain pulls and pad readback.
// Assumes pull requests come from the bench; no timing of its own.
module far_side_model (
  // Device drive
  input  wire logic [2:0] host_oe_i,
  input  wire logic [2:0] card_out_i,
  input  wire logic [2:0] card_oe_i,
  input  wire logic       card_rst_i,
  input  wire logic       card_clk_i,
  // Far-side pulls
  input  wire logic [2:0] host_pull_i,
  input  wire logic [2:0] card_pull_i,
  // Wire levels
  output logic      [2:0] host_line_o,
  output logic      [2:0] card_line_o,
  output logic            rst_sense_o,
  output logic            clk_sense_o
);
  // Pull-ups keep released lines high, so idle reads high both sides
  assign host_line_o = ~(host_oe_i | host_pull_i);
  // Resolved per bit: a released line floats up to its pull-up
  assign card_line_o = ((card_oe_i & card_out_i) | ~card_oe_i) & ~card_pull_i;
  // Healthy pads read back what is driven
  assign rst_sense_o = card_rst_i;
  assign clk_sense_o = card_clk_i;
endmodule : far_side_model

// ---- insert_debounce.sv ----
// Debounces the acceptor switch into an active-low insertion flag.
// Assumes the switch and polarity inputs are synchronous to clk_i.
`include "card_intf_cfg.svh"

module insert_debounce #(
  parameter int CYCLES = 4000000
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Switch
  input  wire logic sw_i,
  input  wire logic pol_i,
  // Flag
  output logic      flag_n_o
);
  localparam int W = $clog2(CYCLES + 1);

  logic         present;
  logic         last_reg;
  logic [W-1:0] cnt_reg;

  // Fold the switch polarity so that one always means present
  assign present = pol_i ? sw_i : ~sw_i;

  // Counter restarts on every change, flag moves only on expiry
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_reg <= 1'b0;
      cnt_reg  <= '0;
      flag_n_o <= `FLAG_N_RST;
    end
    else
    begin
      last_reg <= present;
      if (present != last_reg)
        cnt_reg <= '0;
      else if (cnt_reg != W'(CYCLES - 1))
        cnt_reg <= cnt_reg + 1'b1;
      else
        flag_n_o <= ~present;
    end
  end
endmodule : insert_debounce

// ---- io_channel.sv ----
// One half-duplex open-drain channel between host and card pads.
// Assumes pads are resolved outside; inputs read the wire level.
module io_channel (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pads and control
  chan_if.chan      ch
);
  card_intf_pkg::chan_dir_t dir_reg, dir_next;
  logic host_oe_next;
  logic card_out_next;
  logic card_oe_next;

  // Direction is locked by the first low seen from the both-high idle
  always_comb
  begin
    dir_next      = dir_reg;
    host_oe_next  = 1'b0;
    card_out_next = 1'b0;
    card_oe_next  = 1'b1;
    if (!ch.en)
    begin
      dir_next      = card_intf_pkg::DIR_IDLE;
      card_out_next = ~ch.park;
    end
    else
    begin
      unique case (dir_reg)
        card_intf_pkg::DIR_IDLE:
        begin
          card_oe_next = 1'b0;
          if (!ch.host_in)
          begin
            dir_next     = card_intf_pkg::DIR_H2C;
            card_oe_next = 1'b1;
          end
          else if (!ch.card_in)
          begin
            dir_next     = card_intf_pkg::DIR_C2H;
            host_oe_next = 1'b1;
          end
        end
        card_intf_pkg::DIR_H2C:
        begin
          // A low forced on the card side is never echoed back
          card_oe_next = ~ch.host_in;
          if (ch.host_in)
            dir_next = card_intf_pkg::DIR_IDLE;
        end
        card_intf_pkg::DIR_C2H:
        begin
          card_oe_next = 1'b0;
          host_oe_next = ~ch.card_in;
          if (ch.card_in)
            dir_next = card_intf_pkg::DIR_IDLE;
        end
        default:
          dir_next = card_intf_pkg::DIR_IDLE;
      endcase
    end
  end

  // Pad drivers come straight from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir_reg     <= card_intf_pkg::DIR_IDLE;
      ch.host_out <= 1'b0;
      ch.host_oe  <= 1'b0;
      ch.card_out <= 1'b0;
      ch.card_oe  <= 1'b1;
    end
    else
    begin
      dir_reg     <= dir_next;
      ch.host_out <= 1'b0;
      ch.host_oe  <= host_oe_next;
      ch.card_out <= card_out_next;
      ch.card_oe  <= card_oe_next;
    end
  end
endmodule : io_channel

// ---- tb_top.sv ----
// Directed bench for the card interface control core.
// Assumes design, monitor and far-side model are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 16;
  logic       clk = 1'h0, rst = 1'h1, act_n = 1'h1, sel_n = 1'h1, lvl = 1'h0, pol = 1'h0;
  logic       hrst = 1'h0, hclk = 1'h0, sw = 1'h1, rng = 1'h0;
  logic [2:0] hpull = 3'h0, cpull = 3'h0, hline, cline, hout, hoe, cout, coe;
  logic       en, dis, lvlo, good_n, alarm_n, flag_n, crst, cclk, rsense, csense;
  int         mismatches = 0, n_tests = 0, n;

  always #10 clk = ~clk;

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  card_intf_ctrl #(.DEBOUNCE_CYCLES(DEB)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .ACTIVATION_REQUEST_N_I(act_n), .CHANNEL_SELECT_N_I(sel_n),
    .SUPPLY_LEVEL_SELECT_I(lvl), .SWITCH_POLARITY_SELECT_I(pol), .HOST_RESET_IN_I(hrst),
    .HOST_CLOCK_IN_I(hclk), .ACCEPTOR_SWITCH_IN_I(sw), .SUPPLY_IN_RANGE_I(rng),
    .CARD_RESET_SENSE_I(rsense), .CARD_CLOCK_SENSE_I(csense), .HOST_LINE_IN_I(hline),
    .HOST_LINE_OUT_O(hout), .HOST_LINE_OE_O(hoe), .CARD_LINE_IN_I(cline), .CARD_LINE_OUT_O(cout),
    .CARD_LINE_OE_O(coe), .SUPPLY_ENABLE_O(en), .SUPPLY_DISCHARGE_O(dis), .SUPPLY_LEVEL_O(lvlo),
    .SUPPLY_GOOD_N_O(good_n), .ALARM_N_O(alarm_n), .INSERTION_FLAG_N_O(flag_n),
    .CARD_RESET_OUT_O(crst), .CARD_CLOCK_OUT_O(cclk));
  far_side_model far (
    .host_oe_i(hoe), .card_out_i(cout), .card_oe_i(coe), .card_rst_i(crst), .card_clk_i(cclk),
    .host_pull_i(hpull), .card_pull_i(cpull), .host_line_o(hline), .card_line_o(cline),
    .rst_sense_o(rsense), .clk_sense_o(csense));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task check(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Inputs move on the falling edge, away from sampling
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Bounded wait for the debounced flag
  task wait_flag(input logic e);
    n = 0;
    while (flag_n !== e && n < 60)
    begin
      cyc(1);
      n++;
    end
    if (n == 60)
    begin
      mismatches++;
      $display("[FAIL] flag wait expected %h seen %h", e, flag_n);
      summarize();
    end
  endtask : wait_flag

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    cyc(10);
    rst = 1'h0;
    cyc(1);
    check("enable", en, 3'h0);
    check("discharge", dis, 3'h1);
    check("good", good_n, 3'h1);
    check("card out", cout, 3'h0);
    check("card oe", coe, 3'h7);
    $display("reset test done");
    // Select lowered with the request; level changes later must not stick
    lvl = 1'h1;
    act_n = 1'h0;
    sel_n = 1'h0;
    cyc(1);
    check("enable", en, 3'h1);
    lvl = 1'h0;
    hrst = 1'h1;
    hclk = 1'h1;
    cyc(3);
    check("level", lvlo, 3'h1);
    check("good early", good_n, 3'h1);
    check("card ramp", cout, 3'h7);
    check("host ramp", hoe, 3'h0);
    check("reset early", crst, 3'h0);
    rng = 1'h1;
    cyc(4);
    check("good", good_n, 3'h0);
    check("reset live", {crst, cclk}, 3'h3);
    $display("activation test done");
    // Host drives bit 0, card drives bit 1, no echo back
    hpull = 3'h1;
    cpull = 3'h2;
    cyc(3);
    check("card dir", coe & ~cout, 3'h1);
    check("host dir", hoe, 3'h2);
    hpull = 3'h0;
    cpull = 3'h0;
    cyc(3);
    check("card idle", coe, 3'h0);
    check("host idle", hoe, 3'h0);
    // Deselect: card side forced high, host released, clock still live
    sel_n = 1'h1;
    cyc(4);
    cpull = 3'h1;
    hclk = 1'h0;
    cyc(3);
    check("host off", hoe, 3'h0);
    check("host out", hout, 3'h0);
    check("card forced", cout & coe, 3'h7);
    check("supply kept", {en, good_n}, 3'h2);
    check("clock kept", cclk, 3'h0);
    cpull = 3'h0;
    sel_n = 1'h0;
    $display("channel test done");
    // Short dip ignored, long dip alarms
    rng = 1'h0;
    cyc(100);
    rng = 1'h1;
    cyc(2);
    check("short dip", alarm_n, 3'h1);
    rng = 1'h0;
    cyc(260);
    check("alarm", {alarm_n, en, dis}, 3'h1);
    act_n = 1'h1;
    cyc(3);
    check("idle", {alarm_n, crst, cclk}, 3'h4);
    check("idle lines", cout, 3'h0);
    // Card clock lagging a fast-toggling host clock reads as a pad fault
    rng = 1'h1;
    act_n = 1'h0;
    cyc(4);
    check("good again", good_n, 3'h0);
    repeat (160)
    begin
      hclk = ~hclk;
      cyc(1);
    end
    check("mismatch alarm", alarm_n, 3'h0);
    act_n = 1'h1;
    cyc(3);
    check("mismatch idle", {alarm_n, en, dis}, 3'h5);
    $display("supply fault test done");
    // Both switch polarities: glitch rejected, then insert and remove
    for (int p = 0; p < 2; p++)
    begin
      pol = p[0];
      sw = ~p[0];
      cyc(30);
      check("flag absent", flag_n, 3'h1);
      sw = p[0];
      cyc(5);
      check("flag glitch", flag_n, 3'h1);
      sw = ~p[0];
      cyc(30);
      sw = p[0];
      wait_flag(1'h0);
      check("flag delay", n >= DEB, 3'h1);
      check("flag present", flag_n, 3'h0);
      sw = ~p[0];
      wait_flag(1'h1);
    end
    $display("presence test done");
    summarize();
  end
endmodule : tb_top
